// *** design/cpu_seq_map.vh ***
// Purpose: constants of the bus-cycle sequencer
// Assumes: included by the sequencer and its address unit
// Notes: definitions only
`ifndef CPU_SEQ_MAP_VH
`define CPU_SEQ_MAP_VH

// bus cycle kinds shown on O_CYCLE
`define CYC_FREE 3'h0
`define CYC_FETCH 3'h1
`define CYC_READ 3'h2
`define CYC_WRITE 3'h3
`define CYC_PUSH 3'h4
`define CYC_POP 3'h5
`define CYC_VECTOR 3'h6

`define RW_READ 1'b1
`define RW_WRITE 1'b0

// addressing modes
`define MODE_NONE 4'h0
`define MODE_IMM 4'h1
`define MODE_DIR 4'h2
`define MODE_EXT 4'h3
`define MODE_IX2 4'h4
`define MODE_IX1 4'h5
`define MODE_IX 4'h6
`define MODE_IXP 4'h7
`define MODE_IX1P 4'h8
`define MODE_SP1 4'h9
`define MODE_SP2 4'hA

// instruction classes
`define CLS_RD 3'h0
`define CLS_WR 3'h1
`define CLS_JMP 3'h2
`define CLS_PUSH 3'h3
`define CLS_POP 3'h4
`define CLS_SWI 3'h5
`define CLS_RTS 3'h6
`define CLS_FREE 3'h7

// opcodes steering the sequence
`define OPC_PAGE2 8'h9E
`define OPC_CBEQ_IXP 8'h71
`define OPC_CBEQ_IX1P 8'h61
`define OPC_RTS 8'h81
`define OPC_SWI 8'h83
`define OPC_PULA 8'h86
`define OPC_PSHA 8'h87
`define OPC_PULX 8'h88
`define OPC_PSHX 8'h89
`define OPC_PULH 8'h8A
`define OPC_PSHH 8'h8B

// opcode nibble fields
`define NIB_IMM 4'hA
`define NIB_DIR 4'hB
`define NIB_EXT 4'hC
`define NIB_IX2 4'hD
`define NIB_IX1 4'hE
`define NIB_IX 4'hF
`define NIB_STORE_A 4'h7
`define NIB_STORE_X 4'hF
`define NIB_JUMP 4'hC
`define NIB_CALL 4'hD
`define NIB_P2_SP2 4'hD
`define NIB_P2_SP1 4'hE

// addresses and reset values
`define VEC_RESET 16'hFFFE
`define VEC_SWI 16'hFFFC
`define ZERO_PAGE 8'h00
`define SP_RESET 16'h00FF
`define HX_RESET 16'h0000
`define SWI_LAST 3'h4

`endif

// *** design/ea_calc.v ***
// Purpose: effective address of the indexed, stack and memory modes
// Assumes: operand bytes in instruction order, high byte first
// Notes: purely combinational
`timescale 1ns/10ps
`include "cpu_seq_map.vh"

module ea_calc (
    input wire [3:0] i_mode,
    input wire [15:0] i_hx,
    input wire [15:0] i_sp,
    input wire [7:0] i_op1,
    input wire [7:0] i_op2,
    output reg [15:0] o_ea
);

always @* begin
    case (i_mode)
        `MODE_DIR: o_ea = {`ZERO_PAGE, i_op1};
        `MODE_EXT: o_ea = {i_op1, i_op2};
        `MODE_IX2: o_ea = i_hx + {i_op1, i_op2};
        `MODE_IX1: o_ea = i_hx + {`ZERO_PAGE, i_op1};
        `MODE_IX1P: o_ea = i_hx + {`ZERO_PAGE, i_op1};
        `MODE_IX: o_ea = i_hx;
        `MODE_IXP: o_ea = i_hx;
        `MODE_SP1: o_ea = i_sp + {`ZERO_PAGE, i_op1};
        `MODE_SP2: o_ea = i_sp + {i_op1, i_op2};
        default: o_ea = {i_op1, i_op2};
    endcase
end

endmodule

// *** design/cpu_bus_cycle_sequencer.v ***
// Purpose: bus-cycle sequencer and address modes of an 8-bit core
// Assumes: single-cycle memory, read data valid in the cycle of its address
// Notes: one bus cycle per clock; ALU lives outside this block
//
// Operation
// - idle cycle is one clock, a read
// - fetch reads next program byte, advance counter
// - operand read moves one byte in
// - operand write moves one byte out
// - push writes one byte at stack pointer
// - pop reads one byte through stack pointer
// - vectors from top page, high byte first
// - post-increment mode uses index, then increments
// - byte offset plus index, then increment index
// - word offset added to index pair
// - byte and word offsets on stack pointer
// - full address and zero-page direct modes
`timescale 1ns/10ps
`include "cpu_seq_map.vh"

module cpu_bus_cycle_sequencer (
    input wire I_CLOCK,
    input wire I_SRST,
    input wire [7:0] I_RDATA,
    input wire [7:0] I_STORE_DATA,
    input wire [7:0] I_CCR,
    output wire [15:0] O_ADDR,
    output wire [7:0] O_WDATA,
    output wire O_RW,
    output wire [2:0] O_CYCLE,
    output wire [7:0] O_READ_DATA,
    output wire O_READ_VALID
);

////////////////////////////////////////////////////////////////////////
localparam S_VEC_HI = 9'h001;
localparam S_VEC_LO = 9'h002;
localparam S_OPC = 9'h004;
localparam S_PAGE2 = 9'h008;
localparam S_OPND = 9'h010;
localparam S_ACC = 9'h020;
localparam S_PUSH = 9'h040;
localparam S_POP = 9'h080;
localparam S_FREE = 9'h100;

function [15:0] inc16;
    input [15:0] v;
    begin
        inc16 = v + 16'h0001;
    end
endfunction

function [15:0] dec16;
    input [15:0] v;
    begin
        dec16 = v - 16'h0001;
    end
endfunction

// {class, mode, operand byte count}
function [8:0] decode;
    input page2;
    input [7:0] opc;
    reg [2:0] cls;
    reg [3:0] mode;
    reg [1:0] nb;
    begin
        cls = `CLS_FREE;
        mode = `MODE_NONE;
        nb = 2'h0;
        if (page2) begin
            if (opc[7:4] == `NIB_P2_SP2) begin
                mode = `MODE_SP2;
                nb = 2'h2;
            end else if (opc[7:4] == `NIB_P2_SP1) begin
                mode = `MODE_SP1;
                nb = 2'h1;
            end
            if (mode != `MODE_NONE) begin
                if (opc[3:0] == `NIB_STORE_A)
                    cls = `CLS_WR;
                else if (opc[3:0] != `NIB_JUMP &&
                         opc[3:0] != `NIB_CALL)
                    cls = `CLS_RD;
            end
        end else if (opc[7:4] >= `NIB_IMM) begin
            case (opc[7:4])
                `NIB_IMM: begin
                    mode = `MODE_IMM;
                    nb = 2'h1;
                end
                `NIB_DIR: begin
                    mode = `MODE_DIR;
                    nb = 2'h1;
                end
                `NIB_EXT: begin
                    mode = `MODE_EXT;
                    nb = 2'h2;
                end
                `NIB_IX2: begin
                    mode = `MODE_IX2;
                    nb = 2'h2;
                end
                `NIB_IX1: begin
                    mode = `MODE_IX1;
                    nb = 2'h1;
                end
                default: mode = `MODE_IX;
            endcase
            if (opc[3:0] == `NIB_STORE_A || opc[3:0] == `NIB_STORE_X)
                cls = `CLS_WR;
            else if (opc[3:0] == `NIB_JUMP)
                cls = `CLS_JMP;
            else if (opc[3:0] != `NIB_CALL)
                cls = `CLS_RD;
            // an immediate operand has no address to write or jump to
            if (mode == `MODE_IMM && cls != `CLS_RD)
                cls = `CLS_FREE;
        end else begin
            case (opc)
                `OPC_CBEQ_IXP: begin
                    cls = `CLS_RD;
                    mode = `MODE_IXP;
                    nb = 2'h1;
                end
                `OPC_CBEQ_IX1P: begin
                    cls = `CLS_RD;
                    mode = `MODE_IX1P;
                    nb = 2'h2;
                end
                `OPC_PSHA, `OPC_PSHX, `OPC_PSHH: cls = `CLS_PUSH;
                `OPC_PULA, `OPC_PULX, `OPC_PULH: cls = `CLS_POP;
                `OPC_SWI: cls = `CLS_SWI;
                `OPC_RTS: cls = `CLS_RTS;
                default: cls = `CLS_FREE;
            endcase
        end
        decode = {cls, mode, nb};
    end
endfunction

// interrupt frame order: counter low, counter high, index, acc, flags
function [7:0] swi_byte;
    input [2:0] step;
    input [15:0] pc;
    input [7:0] x;
    input [7:0] a;
    input [7:0] ccr;
    begin
        case (step)
            3'h0: swi_byte = pc[7:0];
            3'h1: swi_byte = pc[15:8];
            3'h2: swi_byte = x;
            3'h3: swi_byte = a;
            default: swi_byte = ccr;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
reg [8:0] state_q, state_d;
reg [15:0] pc_q, pc_d;
reg [15:0] hx_q, hx_d;
reg [15:0] sp_q, sp_d;
reg [7:0] opc_q, opc_d;
reg page2_q, page2_d;
reg [7:0] op1_q, op1_d;
reg [7:0] op2_q, op2_d;
reg [2:0] cnt_q, cnt_d;
reg [15:0] addr_q, addr_d;
reg [7:0] wdata_q, wdata_d;
reg rw_q, rw_d;
reg [2:0] cyc_q, cyc_d;
reg [7:0] rd_q, rd_d;
reg rdv_q, rdv_d;

reg [7:0] opc_n;
reg page2_n;
reg [7:0] op1_n;
reg [7:0] op2_n;
reg decoded;
reg go_exec;
reg go_fetch;
reg [15:0] fetch_addr;
wire [8:0] dec;
wire [2:0] dec_cls;
wire [3:0] dec_mode;
wire [1:0] dec_nb;
wire [15:0] ea;

assign dec = decode(page2_n, opc_n);
assign dec_cls = dec[8:6];
assign dec_mode = dec[5:2];
assign dec_nb = dec[1:0];

ea_calc u_ea (
    .i_mode(dec_mode),
    .i_hx(hx_q),
    .i_sp(sp_q),
    .i_op1(op1_n),
    .i_op2(op2_n),
    .o_ea(ea)
);

// values as they stand once this cycle's read byte is taken
always @* begin
    opc_n = opc_q;
    page2_n = page2_q;
    op1_n = op1_q;
    op2_n = op2_q;
    if (state_q == S_OPC) begin
        opc_n = I_RDATA;
        page2_n = 1'b0;
    end else if (state_q == S_PAGE2) begin
        opc_n = I_RDATA;
        page2_n = 1'b1;
    end else if (state_q == S_OPND) begin
        if (cnt_q == {1'b0, dec_nb})
            op1_n = I_RDATA;
        else
            op2_n = I_RDATA;
    end
end

////////////////////////////////////////////////////////////////////////
always @* begin
    state_d = state_q;
    pc_d = pc_q;
    hx_d = hx_q;
    sp_d = sp_q;
    opc_d = opc_n;
    page2_d = page2_n;
    op1_d = op1_n;
    op2_d = op2_n;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rw_d = `RW_READ;
    cyc_d = `CYC_FREE;
    rd_d = rd_q;
    rdv_d = 1'b0;
    decoded = 1'b0;
    go_exec = 1'b0;
    go_fetch = 1'b0;
    fetch_addr = pc_q;
    case (state_q)
        S_VEC_HI: begin
            op1_d = I_RDATA;
            state_d = S_VEC_LO;
            addr_d = inc16(addr_q);
            cyc_d = `CYC_VECTOR;
        end
        S_VEC_LO: begin
            go_fetch = 1'b1;
            fetch_addr = {op1_q, I_RDATA};
        end
        S_OPC: begin
            if (I_RDATA == `OPC_PAGE2) begin
                state_d = S_PAGE2;
                addr_d = pc_q;
                pc_d = inc16(pc_q);
                cyc_d = `CYC_FETCH;
            end else begin
                decoded = 1'b1;
            end
        end
        S_PAGE2: decoded = 1'b1;
        S_OPND: begin
            if (cnt_q == 3'h1) begin
                go_exec = 1'b1;
            end else begin
                cnt_d = cnt_q - 3'h1;
                addr_d = pc_q;
                pc_d = inc16(pc_q);
                cyc_d = `CYC_FETCH;
            end
        end
        S_ACC: begin
            if (rw_q == `RW_READ) begin
                rd_d = I_RDATA;
                rdv_d = 1'b1;
            end
            if (dec_mode == `MODE_IXP || dec_mode == `MODE_IX1P)
                hx_d = inc16(hx_q);
            go_fetch = 1'b1;
        end
        S_PUSH: begin
            sp_d = dec16(sp_q);
            if (dec_cls == `CLS_SWI && cnt_q == `SWI_LAST) begin
                state_d = S_VEC_HI;
                addr_d = `VEC_SWI;
                cyc_d = `CYC_VECTOR;
            end else if (dec_cls == `CLS_SWI) begin
                cnt_d = cnt_q + 3'h1;
                addr_d = dec16(sp_q);
                wdata_d = swi_byte(cnt_q + 3'h1, pc_q, hx_q[7:0],
                                   I_STORE_DATA, I_CCR);
                rw_d = `RW_WRITE;
                cyc_d = `CYC_PUSH;
            end else begin
                go_fetch = 1'b1;
            end
        end
        S_POP: begin
            sp_d = addr_q;
            if (opc_q == `OPC_PULX) begin
                hx_d = {hx_q[15:8], I_RDATA};
                go_fetch = 1'b1;
            end else if (opc_q == `OPC_PULH) begin
                hx_d = {I_RDATA, hx_q[7:0]};
                go_fetch = 1'b1;
            end else if (opc_q == `OPC_RTS && cnt_q == 3'h0) begin
                op1_d = I_RDATA;
                cnt_d = 3'h1;
                addr_d = inc16(addr_q);
                cyc_d = `CYC_POP;
            end else if (opc_q == `OPC_RTS) begin
                go_fetch = 1'b1;
                fetch_addr = {op1_q, I_RDATA};
            end else begin
                rd_d = I_RDATA;
                rdv_d = 1'b1;
                go_fetch = 1'b1;
            end
        end
        S_FREE: go_fetch = 1'b1;
        default: begin
            state_d = S_VEC_HI;
            addr_d = `VEC_RESET;
            cyc_d = `CYC_VECTOR;
        end
    endcase

    // operand bytes first, then the access cycles of the mode
    if (decoded) begin
        if (dec_nb != 2'h0) begin
            state_d = S_OPND;
            cnt_d = {1'b0, dec_nb};
            addr_d = pc_q;
            pc_d = inc16(pc_q);
            cyc_d = `CYC_FETCH;
        end else begin
            go_exec = 1'b1;
        end
    end

    if (go_exec) begin
        case (dec_cls)
            `CLS_RD: begin
                if (dec_mode == `MODE_IMM) begin
                    rd_d = op1_n;
                    rdv_d = 1'b1;
                    go_fetch = 1'b1;
                end else begin
                    state_d = S_ACC;
                    addr_d = ea;
                    cyc_d = `CYC_READ;
                end
            end
            `CLS_WR: begin
                state_d = S_ACC;
                addr_d = ea;
                wdata_d = I_STORE_DATA;
                rw_d = `RW_WRITE;
                cyc_d = `CYC_WRITE;
            end
            `CLS_JMP: begin
                go_fetch = 1'b1;
                fetch_addr = ea;
            end
            `CLS_PUSH, `CLS_SWI: begin
                state_d = S_PUSH;
                cnt_d = 3'h0;
                addr_d = sp_q;
                rw_d = `RW_WRITE;
                cyc_d = `CYC_PUSH;
                if (dec_cls == `CLS_SWI)
                    wdata_d = swi_byte(3'h0, pc_q, hx_q[7:0],
                                       I_STORE_DATA, I_CCR);
                else if (opc_n == `OPC_PSHX)
                    wdata_d = hx_q[7:0];
                else if (opc_n == `OPC_PSHH)
                    wdata_d = hx_q[15:8];
                else
                    wdata_d = I_STORE_DATA;
            end
            `CLS_POP, `CLS_RTS: begin
                state_d = S_POP;
                cnt_d = 3'h0;
                addr_d = inc16(sp_q);
                cyc_d = `CYC_POP;
            end
            default: begin
                state_d = S_FREE;
                addr_d = pc_q;
                rw_d = `RW_READ;
                cyc_d = `CYC_FREE;
            end
        endcase
    end

    // next opcode only once the whole sequence above is done
    if (go_fetch) begin
        state_d = S_OPC;
        addr_d = fetch_addr;
        pc_d = inc16(fetch_addr);
        rw_d = `RW_READ;
        cyc_d = `CYC_FETCH;
    end
end

////////////////////////////////////////////////////////////////////////
always @(posedge I_CLOCK) begin
    if (I_SRST) begin
        state_q <= S_VEC_HI;
        pc_q <= `VEC_RESET;
        hx_q <= `HX_RESET;
        sp_q <= `SP_RESET;
        opc_q <= 8'h00;
        page2_q <= 1'b0;
        op1_q <= 8'h00;
        op2_q <= 8'h00;
        cnt_q <= 3'h0;
        addr_q <= `VEC_RESET;
        wdata_q <= 8'h00;
        rw_q <= `RW_READ;
        cyc_q <= `CYC_VECTOR;
        rd_q <= 8'h00;
        rdv_q <= 1'b0;
    end else begin
        state_q <= state_d;
        pc_q <= pc_d;
        hx_q <= hx_d;
        sp_q <= sp_d;
        opc_q <= opc_d;
        page2_q <= page2_d;
        op1_q <= op1_d;
        op2_q <= op2_d;
        cnt_q <= cnt_d;
        addr_q <= addr_d;
        wdata_q <= wdata_d;
        rw_q <= rw_d;
        cyc_q <= cyc_d;
        rd_q <= rd_d;
        rdv_q <= rdv_d;
    end
end

assign O_ADDR = addr_q;
assign O_WDATA = wdata_q;
assign O_RW = rw_q;
assign O_CYCLE = cyc_q;
assign O_READ_DATA = rd_q;
assign O_READ_VALID = rdv_q;

endmodule

// *** tb/cpu_seq_props.sv ***
// Purpose: port-level assertions of the bus-cycle sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every sequencer instance
`timescale 1ns/10ps
`include "cpu_seq_map.vh"

module cpu_seq_props (
    input wire I_CLOCK,
    input wire I_SRST,
    input wire [7:0] I_RDATA,
    input wire [7:0] I_STORE_DATA,
    input wire [7:0] I_CCR,
    input wire [15:0] O_ADDR,
    input wire [7:0] O_WDATA,
    input wire O_RW,
    input wire [2:0] O_CYCLE,
    input wire [7:0] O_READ_DATA,
    input wire O_READ_VALID
);
    default clocking cb @(posedge I_CLOCK);
    endclocking

    ////////////////////////////////////////////////////////////////////
    a_free_then_fetch: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_FREE |=> O_CYCLE == `CYC_FETCH &&
        O_ADDR == $past(O_ADDR))
        else $error("free cycle not followed by fetch at same address");
    a_rw_by_kind: assert property (disable iff (I_SRST)
        O_RW == !(O_CYCLE == `CYC_WRITE || O_CYCLE == `CYC_PUSH))
        else $error("read flag does not match cycle kind");
    a_vec_top_page: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_VECTOR |-> O_ADDR[15:8] == 8'hFF)
        else $error("vector read outside top page");
    a_vec_high_first: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_VECTOR && !O_ADDR[0] |=>
        O_CYCLE == `CYC_VECTOR && O_ADDR == $past(O_ADDR) + 16'h0001)
        else $error("vector low byte not read after high byte");
    a_vec_then_fetch: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_VECTOR && O_ADDR[0] |=> O_CYCLE == `CYC_FETCH)
        else $error("no fetch after vector low byte");
    a_push_goes_down: assert property (disable iff (I_SRST)
        (O_CYCLE == `CYC_PUSH) ##1 (O_CYCLE == `CYC_PUSH) |->
        O_ADDR == $past(O_ADDR) - 16'h0001)
        else $error("successive pushes not one address lower");
    a_read_delivers: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_READ |=> O_READ_VALID &&
        O_READ_DATA == $past(I_RDATA))
        else $error("operand read byte not delivered");
    a_valid_cause: assert property (disable iff (I_SRST)
        O_READ_VALID |-> $past(O_CYCLE) inside
        {`CYC_READ, `CYC_FETCH, `CYC_POP})
        else $error("read valid without a read cycle");
    a_write_ends_op: assert property (disable iff (I_SRST)
        O_CYCLE == `CYC_WRITE |=> O_CYCLE == `CYC_FETCH)
        else $error("operand write not last cycle of instruction");
    // no disable here: the reset values themselves are checked
    a_reset_state: assert property (
        I_SRST |=> O_ADDR == `VEC_RESET && O_CYCLE == `CYC_VECTOR &&
        O_RW && !O_READ_VALID)
        else $error("wrong bus state during reset");
endmodule

bind cpu_bus_cycle_sequencer cpu_seq_props props (
    .I_CLOCK(I_CLOCK),
    .I_SRST(I_SRST),
    .I_RDATA(I_RDATA),
    .I_STORE_DATA(I_STORE_DATA),
    .I_CCR(I_CCR),
    .O_ADDR(O_ADDR),
    .O_WDATA(O_WDATA),
    .O_RW(O_RW),
    .O_CYCLE(O_CYCLE),
    .O_READ_DATA(O_READ_DATA),
    .O_READ_VALID(O_READ_VALID)
);

// *** tb/bus_memory.sv ***
// Purpose: zero-wait memory standing on the system bus
// Assumes: read data combinational from the address, writes at edge
// Notes: during writes the read line shows the inverse of last read
`timescale 1ns/10ps

module bus_memory (
    input wire i_clock,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_rw,
    output wire [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    int i;

    initial begin
        last_q = 8'h00;
        for (i = 0; i < 65536; i++) mem[i] = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // undriven line must not look like the previous byte
    assign o_rdata = i_rw ? mem[i_addr] : ~last_q;

    always @(posedge i_clock) begin
        if (i_rw) last_q <= mem[i_addr];
        else mem[i_addr] <= i_wdata;
    end
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the bus-cycle sequencer
// Assumes: memory model on the bus, program poked before each fetch
// Notes: each test task after t_reset starts in the opcode fetch cycle of its instruction
`timescale 1ns/10ps
`include "cpu_seq_map.vh"

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %h got %h", nm, e, g); \
    end end

module testbench;
    logic I_CLOCK, I_SRST;
    logic [7:0] I_STORE_DATA, I_CCR;
    wire [7:0] I_RDATA, O_WDATA, O_READ_DATA;
    wire [15:0] O_ADDR;
    wire O_RW, O_READ_VALID;
    wire [2:0] O_CYCLE;
    logic [15:0] pc;
    int err_count = 0;
    int checks_done = 0;

    cpu_bus_cycle_sequencer DUT (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
        .I_RDATA(I_RDATA), .I_STORE_DATA(I_STORE_DATA), .I_CCR(I_CCR),
        .O_ADDR(O_ADDR), .O_WDATA(O_WDATA), .O_RW(O_RW),
        .O_CYCLE(O_CYCLE), .O_READ_DATA(O_READ_DATA),
        .O_READ_VALID(O_READ_VALID));
    bus_memory MEM (.i_clock(I_CLOCK), .i_addr(O_ADDR),
        .i_wdata(O_WDATA), .i_rw(O_RW), .o_rdata(I_RDATA));

    initial begin
        I_CLOCK = 1'b0;
        forever #5 I_CLOCK = ~I_CLOCK;
    end

    ////////////////////////////////////////////////////////////////////
    task ld(input [15:0] a, input [7:0] d);
        MEM.mem[a] = d;
    endtask

    // checks the cycle on the bus, then steps to the next one
    task cyc(input [2:0] k, input [15:0] a, input r);
        `CHK("cycle kind", k, O_CYCLE)
        `CHK("address", a, O_ADDR)
        `CHK("read flag", r, O_RW)
        @(posedge I_CLOCK);
        #1;
    endtask

    // pokes n instruction bytes at pc and expects n sequential fetches
    task op(input [31:0] b, input int n);
        int i;
        for (i = 0; i < n; i++) ld(pc + 16'(i), b[31 - 8 * i -: 8]);
        for (i = 0; i < n; i++) begin
            cyc(`CYC_FETCH, pc, `RW_READ);
            pc = pc + 16'h0001;
        end
    endtask

    task test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_reset;
        cyc(`CYC_VECTOR, `VEC_RESET, `RW_READ);
        cyc(`CYC_VECTOR, 16'hFFFF, `RW_READ);
        pc = 16'h0100;
    endtask

    task t_free;
        op(32'h9D000000, 1);
        cyc(`CYC_FREE, pc, `RW_READ);
    endtask

    task t_direct;
        ld(16'h0040, 8'h5A);
        op(32'hB6400000, 2);
        cyc(`CYC_READ, 16'h0040, `RW_READ);
        `CHK("read valid", 1'b1, O_READ_VALID)
        `CHK("read data", 8'h5A, O_READ_DATA)
    endtask

    task t_extended;
        I_STORE_DATA = 8'hC3;
        op(32'hC7123400, 3);
        `CHK("write data", 8'hC3, O_WDATA)
        cyc(`CYC_WRITE, 16'h1234, `RW_WRITE);
        `CHK("stored byte", 8'hC3, MEM.mem[16'h1234])
    endtask

    task t_postinc;
        op(32'h71050000, 2);
        cyc(`CYC_READ, 16'h0000, `RW_READ);
        // index now 1; unsigned offset F0 must not sign-extend
        op(32'h61F00500, 3);
        cyc(`CYC_READ, 16'h00F1, `RW_READ);
    endtask

    task t_word_index;
        op(32'hD6300000, 3);
        cyc(`CYC_READ, 16'h3002, `RW_READ);
    endtask

    task t_stack_offset;
        op(32'h9EE61000, 3);
        cyc(`CYC_READ, 16'h010F, `RW_READ);
        op(32'h9ED60100, 4);
        cyc(`CYC_READ, 16'h01FF, `RW_READ);
    endtask

    task t_push_pop;
        I_STORE_DATA = 8'hA7;
        op(32'h87000000, 1);
        `CHK("push data", 8'hA7, O_WDATA)
        cyc(`CYC_PUSH, `SP_RESET, `RW_WRITE);
        op(32'h86000000, 1);
        cyc(`CYC_POP, `SP_RESET, `RW_READ);
        `CHK("pop valid", 1'b1, O_READ_VALID)
        `CHK("pop data", 8'hA7, O_READ_DATA)
    endtask

    // immediate, plain index, index pushes, jump, return through stack
    task t_modes;
        op(32'hA63C0000, 2);
        `CHK("imm valid", 1'b1, O_READ_VALID)
        `CHK("imm data", 8'h3C, O_READ_DATA)
        op(32'hE6400000, 2);
        cyc(`CYC_READ, 16'h0042, `RW_READ);
        // no post-increment: index still 2 below
        op(32'hF6000000, 1);
        cyc(`CYC_READ, 16'h0002, `RW_READ);
        op(32'h89000000, 1);
        `CHK("push index low", 8'h02, O_WDATA)
        cyc(`CYC_PUSH, 16'h00FF, `RW_WRITE);
        op(32'h8B000000, 1);
        `CHK("push index high", 8'h00, O_WDATA)
        cyc(`CYC_PUSH, 16'h00FE, `RW_WRITE);
        op(32'hCC030000, 3);
        pc = 16'h0300;
        op(32'h81000000, 1);
        cyc(`CYC_POP, 16'h00FE, `RW_READ);
        cyc(`CYC_POP, 16'h00FF, `RW_READ);
        // return lands on the two bytes pushed above
        pc = 16'h0002;
    endtask

    task t_swi;
        logic [7:0] exp [0:4];
        int i;
        ld(`VEC_SWI, 8'h02);
        ld(16'hFFFD, 8'h00);
        I_STORE_DATA = 8'h5C;
        I_CCR = 8'hE1;
        op(32'h83000000, 1);
        exp = '{pc[7:0], pc[15:8], 8'h02, 8'h5C, 8'hE1};
        for (i = 0; i < 5; i++) begin
            `CHK("stacked byte", exp[i], O_WDATA)
            cyc(`CYC_PUSH, `SP_RESET - 16'(i), `RW_WRITE);
        end
        cyc(`CYC_VECTOR, `VEC_SWI, `RW_READ);
        cyc(`CYC_VECTOR, 16'hFFFD, `RW_READ);
        cyc(`CYC_FETCH, 16'h0200, `RW_READ);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        I_SRST = 1'b1;
        I_STORE_DATA = 8'h00;
        I_CCR = 8'h00;
        pc = 16'h0000;
        ld(`VEC_RESET, 8'h01);
        ld(16'hFFFF, 8'h00);
        repeat (20) @(posedge I_CLOCK);
        #1;
        I_SRST = 1'b0;
        t_reset;
        t_free;
        t_direct;
        t_extended;
        t_postinc;
        t_word_index;
        t_stack_offset;
        t_push_pop;
        t_modes;
        t_swi;
        test_done;
    end

    // whole run is well under 100 cycles after reset
    initial begin
        #20000;
        err_count++;
        test_done;
    end
endmodule
